// ===== audio_port_one_pin_and_framing_config_tb_top.sv
// Self-checking bench for serial port one pin and framing configuration
`timescale 1ns/10ps
module audio_port_one_pin_and_framing_config_tb_top;
  typedef struct {int sel; logic [7:0] exp;} note_t;
  localparam logic [7:0] P1 = 8'h01;
  logic [7:0] offs[6] = '{8'h03, 8'h05, 8'h08, 8'h09, 8'h0c, 8'h0d};
  logic [7:0] rstv[6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01};
  logic [7:0] msk[6]  = '{8'hff, 8'h80, 8'h7b, 8'h7a, 8'h7b, 8'h07};
  string nm[12] = '{"rdata", "routed", "divider", "out_oe_n", "out_data", "keeper", "bclk_oe_n", "bclk",
                    "wclk_oe_n", "wclk", "dsp_offset", "slot_offset"};
  note_t q[$];
  note_t n;
  int bad_count = 0, num_checks = 0, c;
  logic [31:0] rnd = 32'h2504;
  logic [13:0] pat;
  logic [3:0]  ex;
  logic        frame, bi, wi, d;
  logic        sys_clk_i, rst_n_i, idle_tristate_en_i, data_done_i, port_active_i, codec_up_i, sense_up_i;
  logic        port_out_en_i, processed_data_i, port_two_serial_in_i, int_bitclock_i, int_wordclock_i;
  logic [2:0]  framing_i, gpi_pins_i;
  logic [9:0]  gp_pins_i;
  logic [7:0]  rdata_o, slot_offset_o;
  logic        dsp_offset_active_o, divider_clk_o, divider_src_valid_o, bitclock_out_o, bitclock_oe_n_o;
  logic        wordclock_out_o, wordclock_oe_n_o, serial_out_o, serial_out_oe_n_o, keeper_on_o;
  port_one_pkg::reg_req_t     req_i;
  port_one_pkg::div_sources_t div_src_i;
  port_one_pkg::routed_t      routed_o;

  far_side_model far (.sys_clk_i, .frame_i(frame), .pat_i(pat), .gp_pins_o(gp_pins_i), .gpi_pins_o(gpi_pins_i),
    .p2_data_o(port_two_serial_in_i));
  port_one_config uut (.sys_clk_i, .rst_n_i, .req_i, .framing_i, .idle_tristate_en_i, .data_done_i, .port_active_i,
    .codec_up_i, .sense_up_i, .port_out_en_i, .processed_data_i, .port_two_serial_in_i, .gp_pins_i, .gpi_pins_i,
    .int_bitclock_i, .int_wordclock_i, .div_src_i, .rdata_o, .slot_offset_o, .dsp_offset_active_o, .routed_o,
    .divider_clk_o, .divider_src_valid_o, .bitclock_out_o, .bitclock_oe_n_o, .wordclock_out_o, .wordclock_oe_n_o,
    .serial_out_o, .serial_out_oe_n_o, .keeper_on_o);

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] seen(int s);
    case (s)
      0: return rdata_o;
      1: return {4'h0, routed_o};
      2: return {6'h0, divider_src_valid_o, divider_clk_o};
      3: return {7'h0, serial_out_oe_n_o};
      4: return {7'h0, serial_out_o};
      5: return {7'h0, keeper_on_o};
      6: return {7'h0, bitclock_oe_n_o};
      7: return {7'h0, bitclock_out_o};
      8: return {7'h0, wordclock_oe_n_o};
      9: return {7'h0, wordclock_out_o};
      10: return {7'h0, dsp_offset_active_o};
      default: return slot_offset_o;
    endcase
  endfunction

  // Register access; a read notes its expected data for the next edge
  // Idle cycle after each request so back-to-back calls never drive req_i twice at once
  task automatic acc(logic w, logic [7:0] p, logic [7:0] a, logic [7:0] v);
    req_i = '{w, !w, p, a, v};
    if (!w) q.push_back(note_t'{0, v});
    @(negedge sys_clk_i);
    req_i = '0;
    @(negedge sys_clk_i);
  endtask

  // Let inputs settle, then note one expected output level
  task automatic chk(int s, logic [7:0] e);
    repeat (2) @(negedge sys_clk_i);
    q.push_back(note_t'{s, e});
    @(negedge sys_clk_i);
  endtask

  task automatic close_out();
    $display("TB: %0d checks, %0d mismatches", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Clock at 10 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Oldest notes compared once the edge's updates have landed
  always @(posedge sys_clk_i) begin
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      num_checks++;
      if (seen(n.sel) !== n.exp) begin
        bad_count++;
        $display("CHECK FAILED %s exp %h seen %h", nm[n.sel], n.exp, seen(n.sel));
      end
    end
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    close_out();
  end

  // Main sequence, inputs changed on falling edges only
  initial begin
    {req_i, framing_i, idle_tristate_en_i, data_done_i, port_active_i, codec_up_i, sense_up_i} = '0;
    {port_out_en_i, processed_data_i, int_bitclock_i, int_wordclock_i, div_src_i, frame, pat, rst_n_i} = '0;
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    chk(3, 8'h01);
    chk(5, 8'h01);
    chk(6, 8'h01);
    for (c = 0; c < 6; c++) acc(0, P1, offs[c], rstv[c]);
    // Random writes read back through the writable masks
    for (c = 0; c < 6; c++) begin
      rnd = lfsr(rnd);
      acc(1, P1, offs[c], rnd[7:0]);
      acc(0, P1, offs[c], rnd[7:0] & msk[c]);
    end
    // Wrong page and unmapped address are refused
    acc(1, P1, 8'h03, 8'h5a);
    acc(1, 8'h02, 8'h03, 8'ha5);
    acc(1, P1, 8'h04, 8'hff);
    acc(0, 8'h02, 8'h03, 8'h00);
    acc(0, P1, 8'h04, 8'h00);
    acc(0, P1, 8'h03, 8'h5a);
    chk(11, 8'h5a);
    // Offset flag only in DSP framing with a non-zero offset
    for (c = 0; c < 5; c++) begin
      framing_i = 3'(c);
      chk(10, {7'h0, c == 1});
    end
    framing_i = 3'h1;
    acc(1, P1, 8'h03, 8'h00);
    chk(10, 8'h00);
    // Every selector code with random pins and polarity, port idle
    frame = 1'b1;
    for (c = 0; c < 16; c++) begin
      rnd = lfsr(rnd);
      pat = rnd[13:0];
      {bi, wi} = rnd[15:14];
      acc(1, P1, 8'h08, {1'b0, 4'(c), 1'b0, bi, 1'b0});
      acc(1, P1, 8'h09, {1'b0, 4'(c), 1'b0, wi, 1'b0});
      acc(1, P1, 8'h0c, {1'b0, 4'(c), 3'h0});
      d = c < 10 ? pat[c] : pat[c - 2];
      ex = (c < 10 || (c > 11 && c < 15)) ? {d ^ bi, d ^ wi, d, 1'b1} : 4'h0;
      chk(1, {4'h0, ex});
    end
    // Divider sources; port one bit clock held high on pin one
    acc(1, P1, 8'h08, 8'h00);
    pat = 14'h0001;
    for (c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      div_src_i = rnd[3:0];
      acc(1, P1, 8'h0d, {5'h0, 3'(c)});
      ex = {2'h0, c == 0 || c == 1 || c == 3 || c == 4 || c == 6,
            c == 0 ? rnd[3] : c == 1 ? rnd[2] : c == 3 ? rnd[1] : c == 4 ? 1'b1 : c == 6 ? rnd[0] : 1'b0};
      chk(2, {4'h0, ex});
    end
    // Output source codes with random enables and data
    for (c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      {sense_up_i, port_out_en_i, processed_data_i} = rnd[2:0];
      pat = rnd[16:3];
      acc(1, P1, 8'h0c, {6'h18, 2'(c)});
      d = c % 4 == 1 ? pat[10] : (c % 4 == 2 ? pat[13] : processed_data_i);
      chk(4, {7'h0, d});
      chk(3, {7'h0, c % 4 == 0 ? !sense_up_i : !port_out_en_i});
    end
    // Tail tri-state after frame data, keeper powered down meanwhile
    acc(1, P1, 8'h0c, 8'h63);
    acc(1, P1, 8'h05, 8'h80);
    {port_out_en_i, idle_tristate_en_i, port_active_i} = 3'h7;
    chk(3, 8'h00);
    chk(5, 8'h01);
    data_done_i = 1'b1;
    @(negedge sys_clk_i);
    data_done_i = 1'b0;
    chk(3, 8'h01);
    chk(5, 8'h00);
    acc(1, P1, 8'h05, 8'h00);
    chk(5, 8'h01);
    port_active_i = 1'b0;
    chk(3, 8'h00);
    {idle_tristate_en_i, port_active_i, data_done_i} = 3'h3;
    @(negedge sys_clk_i);
    data_done_i = 1'b0;
    chk(3, 8'h00);
    // Clock outputs gated by activity unless free-running
    for (c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      {port_active_i, codec_up_i, int_bitclock_i, int_wordclock_i, bi, wi} = {c[2:1], rnd[3:0]};
      acc(1, P1, 8'h08, {6'h00, bi, c[0]});
      acc(1, P1, 8'h09, {6'h02, wi, 1'b0});
      d = c[0] | (c[2] & c[1]);
      chk(6, {7'h0, !d});
      chk(8, {7'h0, !d});
      if (d) begin
        chk(7, {7'h0, int_bitclock_i ^ bi});
        chk(9, {7'h0, int_wordclock_i ^ wi});
      end
    end
    // Reset again mid-run: written registers fall back to their reset values
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    for (c = 0; c < 6; c++) acc(0, P1, offs[c], rstv[c]);
    chk(11, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    close_out();
  end
endmodule // audio_port_one_pin_and_framing_config_tb_top

// ===== divider_source_mux.sv
// Chooses the bit-clock divider source by a three-bit code
`timescale 1ns/10ps
module divider_source_mux (
  input  wire logic [2:0]                 sel_i,
  input  wire port_one_pkg::div_sources_t src_i,
  input  wire logic                       port_one_bclk_i,
  output logic                            clk_o,
  output logic                            valid_o
);

  // Reserved codes give a quiet low source
  always_comb begin
    clk_o   = 1'b0;
    valid_o = 1'b1;
    case (sel_i)
      port_one_pkg::DIV_MULT:    clk_o = src_i.mult_clk;
      port_one_pkg::DIV_DAC_MOD: clk_o = src_i.dac_mod_clk;
      port_one_pkg::DIV_ADC_MOD: clk_o = src_i.adc_mod_clk;
      port_one_pkg::DIV_P1_BCLK: clk_o = port_one_bclk_i;
      port_one_pkg::DIV_P2_BCLK: clk_o = src_i.port_two_bclk;
      default:                   valid_o = 1'b0;
    endcase
  end

endmodule // divider_source_mux

// ===== far_side_model.sv
// Far-side pin model: host clocks, word clock and data; pins low between frames, port two data inverted
`timescale 1ns/10ps
module far_side_model (
  input  wire logic        sys_clk_i,
  input  wire logic        frame_i,
  input  wire logic [13:0] pat_i,
  output logic [9:0]       gp_pins_o,
  output logic [2:0]       gpi_pins_o,
  output logic             p2_data_o
);
  logic last = 1'b0;
  // Last data bit kept so a released line shows its inverse, not a stale copy
  always_ff @(posedge sys_clk_i) begin
    if (frame_i) last <= pat_i[13];
  end
  // Clock pins stand still outside frames
  assign gp_pins_o  = frame_i ? pat_i[9:0] : 10'h000;
  assign gpi_pins_o = frame_i ? pat_i[12:10] : 3'h0;
  assign p2_data_o  = frame_i ? pat_i[13] : ~last;
endmodule // far_side_model

// ===== pin_router.sv
// Selects one pin from general purpose and input-only pins by a four-bit code
`timescale 1ns/10ps
module pin_router (
  input  wire logic [3:0] sel_i,
  input  wire logic [9:0] gp_pins_i,
  input  wire logic [2:0] gpi_pins_i,
  output logic            pin_o,
  output logic            valid_o
);

  logic [15:0] table_v;

  // One entry per code; reserved codes pick nothing and read low
  for (genvar k = 0; k < 16; k++) begin : g_code
    if (k < port_one_pkg::NUM_GP) begin : g_gp
      assign table_v[k] = gp_pins_i[k];
    end else if (k >= int'(port_one_pkg::PIN_GPI_ONE) &&
                 k < int'(port_one_pkg::PIN_GPI_ONE) + port_one_pkg::NUM_GPI) begin : g_gpi
      assign table_v[k] = gpi_pins_i[k - int'(port_one_pkg::PIN_GPI_ONE)];
    end else begin : g_res
      assign table_v[k] = 1'b0;
    end
  end

  // Reserved codes flag invalid so the port treats the source as absent
  always_comb begin
    valid_o = (sel_i <= port_one_pkg::PIN_GP_LAST) ||
              (sel_i >= port_one_pkg::PIN_GPI_ONE && sel_i <= port_one_pkg::PIN_GPI_LAST);
    pin_o   = valid_o ? table_v[sel_i] : 1'b0;
  end

endmodule // pin_router

// ===== port_one_config.sv
// Serial port one pin routing, polarity, loopback and divider source configuration
`timescale 1ns/10ps
module port_one_config (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  input  wire port_one_pkg::reg_req_t     req_i,
  input  wire logic [2:0]                 framing_i,
  input  wire logic                       idle_tristate_en_i,
  input  wire logic                       data_done_i,
  input  wire logic                       port_active_i,
  input  wire logic                       codec_up_i,
  input  wire logic                       sense_up_i,
  input  wire logic                       port_out_en_i,
  input  wire logic                       processed_data_i,
  input  wire logic                       port_two_serial_in_i,
  input  wire logic [9:0]                 gp_pins_i,
  input  wire logic [2:0]                 gpi_pins_i,
  input  wire logic                       int_bitclock_i,
  input  wire logic                       int_wordclock_i,
  input  wire port_one_pkg::div_sources_t div_src_i,
  output logic [7:0]                      rdata_o,
  output logic [7:0]                      slot_offset_o,
  output logic                            dsp_offset_active_o,
  output port_one_pkg::routed_t           routed_o,
  output logic                            divider_clk_o,
  output logic                            divider_src_valid_o,
  output logic                            bitclock_out_o,
  output logic                            bitclock_oe_n_o,
  output logic                            wordclock_out_o,
  output logic                            wordclock_oe_n_o,
  output logic                            serial_out_o,
  output logic                            serial_out_oe_n_o,
  output logic                            keeper_on_o
);

  typedef struct packed {
    logic [7:0]            slot_offset;
    logic [7:0]            keeper;
    logic [7:0]            bitclock;
    logic [7:0]            wordclock;
    logic [7:0]            data_route;
    logic [7:0]            div_source;
    logic                  in_tail;
    logic [7:0]            rdata;
    logic                  dsp_off;
    port_one_pkg::routed_t routed;
    logic                  div_clk;
    logic                  div_ok;
    logic                  bclk_out;
    logic                  bclk_oe_n;
    logic                  wclk_out;
    logic                  wclk_oe_n;
    logic                  sout;
    logic                  sout_oe_n;
    logic                  keeper_on;
  } state_t;

  state_t st;
  state_t next_st;

  logic       bclk_raw;
  logic       bclk_ok;
  logic       wclk_raw;
  logic       wclk_ok;
  logic       sin_raw;
  logic       sin_ok;
  logic       div_clk_w;
  logic       div_ok_w;
  logic       page_hit;
  logic       bclk_inv;
  logic       wclk_inv;
  logic       free_run;
  logic [1:0] out_sel;

  // Three pin selectors share one encoding
  pin_router u_bclk_router (
    .sel_i      (st.bitclock[port_one_pkg::SEL_LSB +: 4]),
    .gp_pins_i  (gp_pins_i),
    .gpi_pins_i (gpi_pins_i),
    .pin_o      (bclk_raw),
    .valid_o    (bclk_ok)
  );

  pin_router u_wclk_router (
    .sel_i      (st.wordclock[port_one_pkg::SEL_LSB +: 4]),
    .gp_pins_i  (gp_pins_i),
    .gpi_pins_i (gpi_pins_i),
    .pin_o      (wclk_raw),
    .valid_o    (wclk_ok)
  );

  pin_router u_sin_router (
    .sel_i      (st.data_route[port_one_pkg::SEL_LSB +: 4]),
    .gp_pins_i  (gp_pins_i),
    .gpi_pins_i (gpi_pins_i),
    .pin_o      (sin_raw),
    .valid_o    (sin_ok)
  );

  // Divider source picks from internal clocks or routed bit clocks
  divider_source_mux u_div_mux (
    .sel_i           (st.div_source[port_one_pkg::DIVSRC_LSB +: 3]),
    .src_i           (div_src_i),
    .port_one_bclk_i (bclk_raw),
    .clk_o           (div_clk_w),
    .valid_o         (div_ok_w)
  );

  // Field views of the current registers
  assign page_hit = (req_i.page == port_one_pkg::PAGE_ONE);
  assign bclk_inv = st.bitclock[port_one_pkg::INVERT_BIT];
  assign wclk_inv = st.wordclock[port_one_pkg::INVERT_BIT];
  assign free_run = st.bitclock[port_one_pkg::FREE_RUN_BIT];
  assign out_sel  = st.data_route[port_one_pkg::OUTSEL_LSB +: 2];

  // Next-state logic for registers, routing and output drive
  always_comb begin
    next_st = st;

    // Register writes keep reserved bits at zero
    if (req_i.wr && page_hit) begin
      if (req_i.addr == port_one_pkg::OFF_SLOT_OFFSET) begin
        next_st.slot_offset = req_i.wdata & port_one_pkg::MASK_SLOT_OFFSET;
      end else if (req_i.addr == port_one_pkg::OFF_KEEPER) begin
        next_st.keeper = req_i.wdata & port_one_pkg::MASK_KEEPER;
      end else if (req_i.addr == port_one_pkg::OFF_BITCLOCK) begin
        next_st.bitclock = req_i.wdata & port_one_pkg::MASK_BITCLOCK;
      end else if (req_i.addr == port_one_pkg::OFF_WORDCLOCK) begin
        next_st.wordclock = req_i.wdata & port_one_pkg::MASK_WORDCLOCK;
      end else if (req_i.addr == port_one_pkg::OFF_DATA_ROUTE) begin
        next_st.data_route = req_i.wdata & port_one_pkg::MASK_DATA_ROUTE;
      end else if (req_i.addr == port_one_pkg::OFF_DIV_SOURCE) begin
        next_st.div_source = req_i.wdata & port_one_pkg::MASK_DIV_SOURCE;
      end
    end

    // Read data registered; unmapped or other pages read zero
    next_st.rdata = 8'h00;
    if (req_i.rd && page_hit) begin
      if (req_i.addr == port_one_pkg::OFF_SLOT_OFFSET) begin
        next_st.rdata = st.slot_offset;
      end else if (req_i.addr == port_one_pkg::OFF_KEEPER) begin
        next_st.rdata = st.keeper;
      end else if (req_i.addr == port_one_pkg::OFF_BITCLOCK) begin
        next_st.rdata = st.bitclock;
      end else if (req_i.addr == port_one_pkg::OFF_WORDCLOCK) begin
        next_st.rdata = st.wordclock;
      end else if (req_i.addr == port_one_pkg::OFF_DATA_ROUTE) begin
        next_st.rdata = st.data_route;
      end else if (req_i.addr == port_one_pkg::OFF_DIV_SOURCE) begin
        next_st.rdata = st.div_source;
      end
    end

    // Offset only meaningful in DSP framing; right-justified ignores it
    next_st.dsp_off = (framing_i == port_one_pkg::FMT_DSP) && (st.slot_offset != 8'h00);

    // Polarity applied after routing; reserved codes give no source
    next_st.routed.bitclock  = bclk_ok && (bclk_raw ^ bclk_inv);
    next_st.routed.wordclock = wclk_ok && (wclk_raw ^ wclk_inv);
    next_st.routed.serial_in = sin_ok && sin_raw;
    next_st.routed.valid     = bclk_ok && wclk_ok && sin_ok;
    next_st.div_clk          = div_clk_w;
    next_st.div_ok           = div_ok_w;

    // Clock outputs gated unless free-running
    next_st.bclk_out  = int_bitclock_i ^ bclk_inv;
    next_st.wclk_out  = int_wordclock_i ^ wclk_inv;
    next_st.bclk_oe_n = !(free_run || (port_active_i && codec_up_i));
    next_st.wclk_oe_n = !(free_run || (port_active_i && codec_up_i));

    // Tail of frame: set when data ends, cleared when port goes idle
    if (data_done_i) begin
      next_st.in_tail = 1'b1;
    end else if (!port_active_i) begin
      next_st.in_tail = 1'b0;
    end

    // Serial-out source and buffer enable
    case (out_sel)
      port_one_pkg::OUT_PATH_SENSE: begin
        next_st.sout      = processed_data_i;
        next_st.sout_oe_n = !sense_up_i;
      end
      port_one_pkg::OUT_LOOP_ONE: begin
        next_st.sout      = st.routed.serial_in;
        next_st.sout_oe_n = !port_out_en_i;
      end
      port_one_pkg::OUT_LOOP_TWO: begin
        next_st.sout      = port_two_serial_in_i;
        next_st.sout_oe_n = !port_out_en_i;
      end
      default: begin
        next_st.sout      = processed_data_i;
        next_st.sout_oe_n = !port_out_en_i;
      end
    endcase
    if (idle_tristate_en_i && (data_done_i || st.in_tail)) begin
      next_st.sout_oe_n = 1'b1;
    end

    // Keeper is powered down only while the pin floats; new keeper bit so a write lines up with the pin
    next_st.keeper_on = !(next_st.keeper[port_one_pkg::KEEPER_BIT] && next_st.sout_oe_n);
  end

  // Single state register; synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st             <= '0;
      st.slot_offset <= port_one_pkg::RST_SLOT_OFFSET;
      st.keeper      <= port_one_pkg::RST_KEEPER;
      st.bitclock    <= port_one_pkg::RST_BITCLOCK;
      st.wordclock   <= port_one_pkg::RST_WORDCLOCK;
      st.data_route  <= port_one_pkg::RST_DATA_ROUTE;
      st.div_source  <= port_one_pkg::RST_DIV_SOURCE;
      st.bclk_oe_n   <= 1'b1;
      st.wclk_oe_n   <= 1'b1;
      st.sout_oe_n   <= 1'b1;
      st.keeper_on   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign rdata_o             = st.rdata;
  assign slot_offset_o       = st.slot_offset;
  assign dsp_offset_active_o = st.dsp_off;
  assign routed_o            = st.routed;
  assign divider_clk_o       = st.div_clk;
  assign divider_src_valid_o = st.div_ok;
  assign bitclock_out_o      = st.bclk_out;
  assign bitclock_oe_n_o     = st.bclk_oe_n;
  assign wordclock_out_o     = st.wclk_out;
  assign wordclock_oe_n_o    = st.wclk_oe_n;
  assign serial_out_o        = st.sout;
  assign serial_out_oe_n_o   = st.sout_oe_n;
  assign keeper_on_o         = st.keeper_on;

  // Checks on register and output behaviour
  a_clock_gate_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!free_run && !(port_active_i && codec_up_i)) |=> bitclock_oe_n_o && wordclock_oe_n_o)
    else $error("clock driven while port idle");
  a_free_run_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    free_run |=> !bitclock_oe_n_o)
    else $error("free-running clock not driven");
  a_keeper_pwrdn: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st.keeper[port_one_pkg::KEEPER_BIT] && serial_out_oe_n_o) |-> !keeper_on_o)
    else $error("keeper on while output floats");
  a_keeper_default: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !st.keeper[port_one_pkg::KEEPER_BIT] |-> keeper_on_o)
    else $error("keeper off while disabled");
  a_sense_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (out_sel == port_one_pkg::OUT_PATH_SENSE && !sense_up_i && !data_done_i) |=> serial_out_oe_n_o)
    else $error("output enabled without sensing");
  a_loop_one_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (out_sel == port_one_pkg::OUT_LOOP_ONE) |=> serial_out_o == $past(st.routed.serial_in))
    else $error("loopback one data mismatch");
  a_loop_two_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (out_sel == port_one_pkg::OUT_LOOP_TWO) |=> serial_out_o == $past(port_two_serial_in_i))
    else $error("loopback two data mismatch");
  a_port_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (out_sel == port_one_pkg::OUT_PATH_PORT && !idle_tristate_en_i) |=> serial_out_oe_n_o == !$past(port_out_en_i))
    else $error("port enable not followed");
  a_tail_tristate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (idle_tristate_en_i && data_done_i) |=> serial_out_oe_n_o)
    else $error("output driven in frame tail");
  a_reserved_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !bclk_ok |=> !routed_o.bitclock && !routed_o.valid)
    else $error("reserved code routed a pin");
  a_div_reserved: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st.div_source[port_one_pkg::DIVSRC_LSB +: 3] == 3'h2) |=> !divider_src_valid_o)
    else $error("reserved divider source valid");
  a_offset_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (req_i.wr && page_hit && req_i.addr == port_one_pkg::OFF_SLOT_OFFSET) |=> slot_offset_o == $past(req_i.wdata))
    else $error("slot offset not stored");
  a_bclk_invert: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bclk_ok |=> routed_o.bitclock == ($past(bclk_raw) ^ $past(bclk_inv)))
    else $error("bit clock polarity wrong");
  a_wclk_invert: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wclk_ok |=> routed_o.wordclock == ($past(wclk_raw) ^ $past(wclk_inv)))
    else $error("word clock polarity wrong");

endmodule // port_one_config

// ===== port_one_pkg.sv
// Shared constants and types for serial port one pin and framing configuration
package port_one_pkg;

  // Register offsets on page one
  localparam logic [7:0] OFF_SLOT_OFFSET = 8'h03;
  localparam logic [7:0] OFF_KEEPER      = 8'h05;
  localparam logic [7:0] OFF_BITCLOCK    = 8'h08;
  localparam logic [7:0] OFF_WORDCLOCK   = 8'h09;
  localparam logic [7:0] OFF_DATA_ROUTE  = 8'h0c;
  localparam logic [7:0] OFF_DIV_SOURCE  = 8'h0d;
  localparam logic [7:0] PAGE_ONE        = 8'h01;

  // Reset values
  localparam logic [7:0] RST_SLOT_OFFSET = 8'h00;
  localparam logic [7:0] RST_KEEPER      = 8'h00;
  localparam logic [7:0] RST_BITCLOCK    = 8'h00;
  localparam logic [7:0] RST_WORDCLOCK   = 8'h08;
  localparam logic [7:0] RST_DATA_ROUTE  = 8'h00;
  localparam logic [7:0] RST_DIV_SOURCE  = 8'h01;

  // Writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_SLOT_OFFSET = 8'hff;
  localparam logic [7:0] MASK_KEEPER      = 8'h80;
  localparam logic [7:0] MASK_BITCLOCK    = 8'h7b;
  localparam logic [7:0] MASK_WORDCLOCK   = 8'h7a;
  localparam logic [7:0] MASK_DATA_ROUTE  = 8'h7b;
  localparam logic [7:0] MASK_DIV_SOURCE  = 8'h07;

  // Field positions
  localparam int KEEPER_BIT   = 7;
  localparam int SEL_LSB      = 3;
  localparam int INVERT_BIT   = 1;
  localparam int FREE_RUN_BIT = 0;
  localparam int OUTSEL_LSB   = 0;
  localparam int DIVSRC_LSB   = 0;

  // Pin selector codes
  localparam logic [3:0] PIN_GP_LAST  = 4'h9;
  localparam logic [3:0] PIN_GPI_ONE  = 4'hc;
  localparam logic [3:0] PIN_GPI_LAST = 4'he;
  localparam int         NUM_GP       = 10;
  localparam int         NUM_GPI      = 3;

  // Framing field codes
  localparam logic [2:0] FMT_I2S  = 3'h0;
  localparam logic [2:0] FMT_DSP  = 3'h1;
  localparam logic [2:0] FMT_RJF  = 3'h2;
  localparam logic [2:0] FMT_LJF  = 3'h3;
  localparam logic [2:0] FMT_MONO = 3'h4;

  // Serial-out source codes
  localparam logic [1:0] OUT_PATH_SENSE = 2'h0;
  localparam logic [1:0] OUT_LOOP_ONE   = 2'h1;
  localparam logic [1:0] OUT_LOOP_TWO   = 2'h2;
  localparam logic [1:0] OUT_PATH_PORT  = 2'h3;

  // Divider source codes
  localparam logic [2:0] DIV_MULT    = 3'h0;
  localparam logic [2:0] DIV_DAC_MOD = 3'h1;
  localparam logic [2:0] DIV_ADC_MOD = 3'h3;
  localparam logic [2:0] DIV_P1_BCLK = 3'h4;
  localparam logic [2:0] DIV_P2_BCLK = 3'h6;

  // Register read or write request from the control interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Routed clock and data inputs after selection
  typedef struct packed {
    logic bitclock;
    logic wordclock;
    logic serial_in;
    logic valid;
  } routed_t;

  // Source clocks for the bit-clock divider
  typedef struct packed {
    logic mult_clk;
    logic dac_mod_clk;
    logic adc_mod_clk;
    logic port_two_bclk;
  } div_sources_t;

endpackage : port_one_pkg
